// ### logic/tvi_ctrl.sv
// Two-level vectored interrupt controller: registers, flags, poll, vector, level tracking
//
// Notes on behaviour
// RULE1 - Each source has its own enable; bit 7 of low enable gates all.
// RULE2 - Enable 0 disables, 1 enables; with gate set any enabled source accepted.
// RULE3 - One priority bit per source: 0 low, 1 high.
// RULE4 - High may pre-empt low routine; nothing pre-empts a high routine.
// RULE5 - Simultaneous requests of different level: high serviced first.
// RULE6 - Same level: fixed poll order from external 0 down to timer 2 overflow.
// RULE7 - Flags sampled at sample point; poll next machine cycle, issue vectored call.
// RULE8 - No call while a routine of equal or higher level is active.
// RULE9 - Call only in the final machine cycle of an instruction.
// RULE10 - After return or enable/priority access, wait one more instruction.
// RULE11 - No memory of blocked requests; every poll is new.
// RULE12 - Acknowledge clears timer 0/1 and edge external flags; others stay set.
// RULE13 - Acknowledge is a long call pushing PC without status word, then vector.
// RULE14 - Vectors eight bytes apart from 0003h to 0073h in documented order.
// RULE15 - Return clears the active-level flip-flop, then pops the PC.
// RULE16 - Low enable: gate, converter, I2C, UART, timer1, ext1, timer0, ext0.
// RULE17 - High enable: timer2, compare 2..0, capture 3..0.
// RULE18 - Low priority: bits 6..0 as low enable; bit 7 reserved.
// RULE19 - High priority layout matches high enable register.
// RULE20 - Spare capture pins act as external interrupts on rise, fall or both.
// RULE21 - Level external flag stays set while the pin is low.
// RULE22 - Software set/clear acts like hardware, except converter flag cannot be set.
// RULE23 - Core sees request, vector, level; level active only when core takes call.
`timescale 1ns/10ps
module tvi_ctrl
  import tvi_pkg::*;
#(
  parameter int N_SRC = NSRC
) (
  input wire logic core_clk,
  input wire logic rst,
  // Core timing
  input wire logic sample_pt,
  input wire logic mc_start,
  input wire logic last_cycle,
  input wire logic instr_done,
  input wire logic return_from_interrupt_exec,
  // Special function register port
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Flag register writes for the request flags, one bit per source
  input wire logic [N_SRC-1:0] flag_wr,
  input wire logic [N_SRC-1:0] flag_wdata,
  output logic [N_SRC-1:0] flag_q,
  // Peripheral events (internal sources, same clock)
  input wire logic [N_SRC-1:0] periph_set,
  // External pins, active low, plus capture pins
  input wire logic ext0_pin_n,
  input wire logic ext1_pin_n,
  input wire logic ext0_edge_mode,
  input wire logic ext1_edge_mode,
  input wire logic [3:0] cap_pin,
  input wire logic [7:0] cap_edge_sel,
  // Core handshake
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic irq_level,
  input wire logic irq_taken,
  output logic [1:0] active_levels
);
  logic [7:0] en_lo_r;
  logic [7:0] en_hi_r;
  logic [7:0] pri_lo_r;
  logic [7:0] pri_hi_r;
  logic [N_SRC-1:0] en_vec;
  logic [N_SRC-1:0] pri_vec;
  logic [N_SRC-1:0] sample_r;
  logic [N_SRC-1:0] hw_set;
  logic [N_SRC-1:0] ack_clr;
  logic [N_SRC-1:0] hold_lvl;
  logic [N_SRC-1:0] sw_ok;
  logic act_lo_r;
  logic act_hi_r;
  logic block_r;
  logic reg_touch;
  logic [3:0] win_idx;
  logic win_found;
  logic win_pri;
  logic [3:0] sel_idx_r;
  logic sel_pri_r;
  logic [15:0] vec_r;
  tvi_state_t state_r;
  tvi_state_t state_nxt;
  logic x0_lvl;
  logic x0_fall;
  logic x1_lvl;
  logic x1_fall;
  logic [3:0] cap_rise;
  logic [3:0] cap_fall;

  // Per-source enable and priority in poll order
  always_comb begin
    en_vec = '0;
    pri_vec = '0;
    en_vec[SRC_EXT0] = en_lo_r[0];  // see RULE16
    en_vec[SRC_TMR0] = en_lo_r[1];
    en_vec[SRC_EXT1] = en_lo_r[2];
    en_vec[SRC_TMR1] = en_lo_r[3];
    en_vec[SRC_UART] = en_lo_r[4];
    en_vec[SRC_I2C] = en_lo_r[5];
    en_vec[SRC_CONV] = en_lo_r[6];
    en_vec[SRC_CAP0] = en_hi_r[0];  // see RULE17
    en_vec[SRC_CAP1] = en_hi_r[1];
    en_vec[SRC_CAP2] = en_hi_r[2];
    en_vec[SRC_CAP3] = en_hi_r[3];
    en_vec[SRC_CMP0] = en_hi_r[4];
    en_vec[SRC_CMP1] = en_hi_r[5];
    en_vec[SRC_CMP2] = en_hi_r[6];
    en_vec[SRC_TMR2] = en_hi_r[7];
    pri_vec[SRC_EXT0] = pri_lo_r[0];  // see RULE18
    pri_vec[SRC_TMR0] = pri_lo_r[1];
    pri_vec[SRC_EXT1] = pri_lo_r[2];
    pri_vec[SRC_TMR1] = pri_lo_r[3];
    pri_vec[SRC_UART] = pri_lo_r[4];
    pri_vec[SRC_I2C] = pri_lo_r[5];
    pri_vec[SRC_CONV] = pri_lo_r[6];
    pri_vec[SRC_CAP0] = pri_hi_r[0];  // see RULE19
    pri_vec[SRC_CAP1] = pri_hi_r[1];
    pri_vec[SRC_CAP2] = pri_hi_r[2];
    pri_vec[SRC_CAP3] = pri_hi_r[3];
    pri_vec[SRC_CMP0] = pri_hi_r[4];
    pri_vec[SRC_CMP1] = pri_hi_r[5];
    pri_vec[SRC_CMP2] = pri_hi_r[6];
    pri_vec[SRC_TMR2] = pri_hi_r[7];
  end

  // Register writes; reserved priority bit stays zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_lo_r <= REG_RESET;
      en_hi_r <= REG_RESET;
      pri_lo_r <= REG_RESET;
      pri_hi_r <= REG_RESET;
    end else if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_EN_LO: en_lo_r <= sfr_wdata;
        ADDR_EN_HI: en_hi_r <= sfr_wdata;
        ADDR_PRI_LO: pri_lo_r <= sfr_wdata & PRI_LO_RSVD_MASK;
        ADDR_PRI_HI: pri_hi_r <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; other addresses belong to other blocks and read as zero
  always_comb begin
    sfr_hit = 1'b1;
    unique case (sfr_addr)
      ADDR_EN_LO: sfr_rdata = en_lo_r;
      ADDR_EN_HI: sfr_rdata = en_hi_r;
      ADDR_PRI_LO: sfr_rdata = pri_lo_r;
      ADDR_PRI_HI: sfr_rdata = pri_hi_r;
      default: begin
        sfr_rdata = REG_RESET;
        sfr_hit = 1'b0;
      end
    endcase
  end

  assign reg_touch = (sfr_wr || sfr_rd) && ((sfr_addr == ADDR_EN_LO) || (sfr_addr == ADDR_EN_HI) ||
                     (sfr_addr == ADDR_PRI_LO) || (sfr_addr == ADDR_PRI_HI));

  // External pins arrive asynchronously
  tvi_pin_sync u_sync_x0 (
    .core_clk(core_clk),
    .rst(rst),
    .pin(ext0_pin_n),
    .level(x0_lvl),
    .rise(),
    .fall(x0_fall)
  );

  tvi_pin_sync u_sync_x1 (
    .core_clk(core_clk),
    .rst(rst),
    .pin(ext1_pin_n),
    .level(x1_lvl),
    .rise(),
    .fall(x1_fall)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cap
      tvi_pin_sync u_sync_cap (
        .core_clk(core_clk),
        .rst(rst),
        .pin(cap_pin[gi]),
        .level(),
        .rise(cap_rise[gi]),
        .fall(cap_fall[gi])
      );
    end
  endgenerate

  // Hardware set sources: peripherals, external edges/levels, capture pin edges
  always_comb begin
    hw_set = periph_set;
    hold_lvl = '0;
    hw_set[SRC_EXT0] = periph_set[SRC_EXT0] | (ext0_edge_mode & x0_fall);
    hw_set[SRC_EXT1] = periph_set[SRC_EXT1] | (ext1_edge_mode & x1_fall);
    hold_lvl[SRC_EXT0] = !ext0_edge_mode && !x0_lvl;  // see RULE21
    hold_lvl[SRC_EXT1] = !ext1_edge_mode && !x1_lvl;  // see RULE21
    // Spare capture pins raise their capture flags on the selected edges, see RULE20
    hw_set[SRC_CAP0] = periph_set[SRC_CAP0] | (cap_edge_sel[1] & cap_fall[0]) | (cap_edge_sel[0] & cap_rise[0]);
    hw_set[SRC_CAP1] = periph_set[SRC_CAP1] | (cap_edge_sel[3] & cap_fall[1]) | (cap_edge_sel[2] & cap_rise[1]);
    hw_set[SRC_CAP2] = periph_set[SRC_CAP2] | (cap_edge_sel[5] & cap_fall[2]) | (cap_edge_sel[4] & cap_rise[2]);
    hw_set[SRC_CAP3] = periph_set[SRC_CAP3] | (cap_edge_sel[7] & cap_fall[3]) | (cap_edge_sel[6] & cap_rise[3]);
    sw_ok = '1;
    sw_ok[SRC_CONV] = 1'b0;  // see RULE22
  end

  // Acknowledge clears only timer 0/1 and edge-mode external flags
  always_comb begin
    ack_clr = '0;
    if (state_r == TVI_REQ && irq_taken) begin
      ack_clr[sel_idx_r] = (sel_idx_r == SRC_TMR0) || (sel_idx_r == SRC_TMR1) ||  // see RULE12
                           (sel_idx_r == SRC_EXT0 && ext0_edge_mode) ||
                           (sel_idx_r == SRC_EXT1 && ext1_edge_mode);
    end
  end

  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_flag
      tvi_req_flag u_flag (
        .core_clk(core_clk),
        .rst(rst),
        .hw_set(hw_set[gi]),
        .sw_set_ok(sw_ok[gi]),
        .sw_wr(flag_wr[gi]),
        .sw_val(flag_wdata[gi]),
        .ack_clr(ack_clr[gi]),
        .hold_level(hold_lvl[gi]),
        .flag(flag_q[gi])
      );
    end
  endgenerate

  // Snapshot of enabled flags at the sample point; overwritten at every sample point, nothing kept
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_r <= '0;
    end else if (sample_pt) begin
      sample_r <= flag_q & en_vec & {N_SRC{en_lo_r[GATE_BIT]}};  // see RULE1, RULE2, RULE7, RULE11
    end
  end

  // Winner: any high pending beats low, then lowest index in poll order
  always_comb begin
    logic [N_SRC-1:0] hi_set;
    logic [N_SRC-1:0] pick;
    hi_set = sample_r & pri_vec;
    pick = (|hi_set) ? hi_set : sample_r;  // see RULE3, RULE5
    win_found = |sample_r;
    win_pri = |hi_set;
    win_idx = '0;
    for (int k = N_SRC - 1; k >= 0; k--) begin
      if (pick[k]) begin
        win_idx = 4'(k);  // see RULE6
      end
    end
  end

  // Vector lookup by source
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [15:0] v;
    unique case (idx)
      SRC_EXT0: v = VEC_EXT0;  // see RULE14
      SRC_I2C: v = VEC_I2C;
      SRC_CONV: v = VEC_CONV;
      SRC_TMR0: v = VEC_TMR0;
      SRC_CAP0: v = VEC_CAP0;
      SRC_CMP0: v = VEC_CMP0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_CAP1: v = VEC_CAP1;
      SRC_CMP1: v = VEC_CMP1;
      SRC_TMR1: v = VEC_TMR1;
      SRC_CAP2: v = VEC_CAP2;
      SRC_CMP2: v = VEC_CMP2;
      SRC_UART: v = VEC_UART;
      SRC_CAP3: v = VEC_CAP3;
      SRC_TMR2: v = VEC_TMR2;
      default: v = VEC_EXT0;
    endcase
    return v;
  endfunction

  // Block window after return or register access, released by a completed later instruction
  always_ff @(posedge core_clk) begin
    if (rst) begin
      block_r <= 1'b0;
    end else if (return_from_interrupt_exec || reg_touch) begin
      block_r <= 1'b1;  // see RULE10
    end else if (instr_done) begin
      block_r <= 1'b0;
    end
  end

  // Call allowed only past an active routine of lower level
  logic pre_ok;
  assign pre_ok = win_pri ? !act_hi_r : !(act_hi_r || act_lo_r);  // see RULE4, RULE8

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TVI_IDLE: begin
        if (mc_start && win_found && pre_ok && last_cycle && !block_r && !return_from_interrupt_exec && !reg_touch) begin
          state_nxt = TVI_REQ;  // see RULE9
        end
      end
      TVI_REQ: if (irq_taken) state_nxt = TVI_HOLD;
      // Wait for the next machine cycle so one poll can never issue two calls
      TVI_HOLD: if (mc_start) state_nxt = TVI_IDLE;
      default: state_nxt = TVI_IDLE;
    endcase
  end

  // Latch the chosen source so vector and level stay steady while requested
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= TVI_IDLE;
      sel_idx_r <= '0;
      sel_pri_r <= 1'b0;
      vec_r <= 16'h_0000;
    end else begin
      state_r <= state_nxt;
      if (state_r == TVI_IDLE && state_nxt == TVI_REQ) begin
        sel_idx_r <= win_idx;
        sel_pri_r <= win_pri;
        vec_r <= vec_of(win_idx);  // see RULE13
      end
    end
  end

  // Active level flip-flops: set when core takes the call, return clears highest
  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_lo_r <= 1'b0;
      act_hi_r <= 1'b0;
    end else if (state_r == TVI_REQ && irq_taken) begin
      if (sel_pri_r) begin
        act_hi_r <= 1'b1;  // see RULE23
      end else begin
        act_lo_r <= 1'b1;
      end
    end else if (return_from_interrupt_exec) begin
      if (act_hi_r) begin
        act_hi_r <= 1'b0;  // see RULE15
      end else begin
        act_lo_r <= 1'b0;
      end
    end
  end

  assign irq_req = (state_r == TVI_REQ);  // see RULE23
  assign irq_vector = vec_r;
  assign irq_level = sel_pri_r;
  assign active_levels = {act_hi_r, act_lo_r};
endmodule

// ### logic/tvi_pkg.sv
// Package: register addresses, bit layout, source order and vectors for the interrupt controller
package tvi_pkg;
  localparam int NSRC = 15;
  // Special function register addresses
  localparam logic [7:0] ADDR_EN_LO = 8'h_A8;   // enable low group
  localparam logic [7:0] ADDR_EN_HI = 8'h_E8;
  localparam logic [7:0] ADDR_PRI_LO = 8'h_B8;
  localparam logic [7:0] ADDR_PRI_HI = 8'h_F8;
  localparam logic [7:0] REG_RESET = 8'h_00;
  localparam logic [7:0] PRI_LO_RSVD_MASK = 8'h_7F;
  localparam int GATE_BIT = 7;
  // Source index (poll order, 0 highest)
  localparam logic [3:0] SRC_EXT0 = 4'h_0;
  localparam logic [3:0] SRC_I2C = 4'h_1;
  localparam logic [3:0] SRC_CONV = 4'h_2;
  localparam logic [3:0] SRC_TMR0 = 4'h_3;
  localparam logic [3:0] SRC_CAP0 = 4'h_4;
  localparam logic [3:0] SRC_CMP0 = 4'h_5;
  localparam logic [3:0] SRC_EXT1 = 4'h_6;
  localparam logic [3:0] SRC_CAP1 = 4'h_7;
  localparam logic [3:0] SRC_CMP1 = 4'h_8;
  localparam logic [3:0] SRC_TMR1 = 4'h_9;
  localparam logic [3:0] SRC_CAP2 = 4'h_A;
  localparam logic [3:0] SRC_CMP2 = 4'h_B;
  localparam logic [3:0] SRC_UART = 4'h_C;
  localparam logic [3:0] SRC_CAP3 = 4'h_D;
  localparam logic [3:0] SRC_TMR2 = 4'h_E;
  // Vector table by source, eight bytes apart; address order is not poll order
  localparam logic [15:0] VEC_EXT0 = 16'h_0003;
  localparam logic [15:0] VEC_TMR0 = 16'h_000B;
  localparam logic [15:0] VEC_EXT1 = 16'h_0013;
  localparam logic [15:0] VEC_TMR1 = 16'h_001B;
  localparam logic [15:0] VEC_UART = 16'h_0023;
  localparam logic [15:0] VEC_I2C = 16'h_002B;
  localparam logic [15:0] VEC_CAP0 = 16'h_0033;
  localparam logic [15:0] VEC_CAP1 = 16'h_003B;
  localparam logic [15:0] VEC_CAP2 = 16'h_0043;
  localparam logic [15:0] VEC_CAP3 = 16'h_004B;
  localparam logic [15:0] VEC_CONV = 16'h_0053;
  localparam logic [15:0] VEC_CMP0 = 16'h_005B;
  localparam logic [15:0] VEC_CMP1 = 16'h_0063;
  localparam logic [15:0] VEC_CMP2 = 16'h_006B;
  localparam logic [15:0] VEC_TMR2 = 16'h_0073;
  // Capture-pin edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h_0;
  localparam logic [1:0] EDGE_RISE = 2'h_1;
  localparam logic [1:0] EDGE_FALL = 2'h_2;
  localparam logic [1:0] EDGE_BOTH = 2'h_3;
  typedef enum logic [1:0] {
    TVI_IDLE = 2'b00,
    TVI_REQ = 2'b01,
    TVI_HOLD = 2'b11
  } tvi_state_t;
endpackage

// ### logic/tvi_pin_sync.sv
// Three-stage pin synchroniser with agreeing-stage edge detect
`timescale 1ns/10ps
module tvi_pin_sync
  import tvi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // Stage one is read only by stage two; stages reset high, so a pin idling low shows one false fall
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lvl_r <= 1'b1;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end

  assign level = lvl_r;
  assign rise = (s2_r == s3_r) && s3_r && !lvl_r;
  assign fall = (s2_r == s3_r) && !s3_r && lvl_r;
endmodule

// ### logic/tvi_req_flag.sv
// One interrupt request flag: hardware set, software write, acknowledge clear
`timescale 1ns/10ps
module tvi_req_flag (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hw_set,
  input wire logic sw_set_ok,
  input wire logic sw_wr,
  input wire logic sw_val,
  input wire logic ack_clr,
  input wire logic hold_level,
  output logic flag
);
  logic flag_r;

  // Hardware set wins over every clear; a held level keeps the flag up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (hw_set || hold_level) begin
      flag_r <= 1'b1;
    end else if (sw_wr) begin
      flag_r <= sw_val && sw_set_ok;
    end else if (ack_clr) begin
      flag_r <= 1'b0;
    end
  end

  assign flag = flag_r;
endmodule

// ### testbench/tvi_ctrl_checker.sv
// Port-level assertion checker for the two-level interrupt controller
`timescale 1ns/10ps
module tvi_ctrl_checker
  import tvi_pkg::*;
#(
  parameter int N_SRC = NSRC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mc_start,
  input wire logic last_cycle,
  input wire logic instr_done,
  input wire logic return_from_interrupt_exec,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_hit,
  input wire logic [N_SRC-1:0] flag_wr,
  input wire logic [N_SRC-1:0] flag_q,
  input wire logic [N_SRC-1:0] periph_set,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic irq_level,
  input wire logic irq_taken,
  input wire logic [1:0] active_levels
);
  logic gate_r;
  logic blk_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow of the global gate and of the hold-off after a return or register access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gate_r <= 1'b0;
      blk_r <= 1'b0;
    end else begin
      if (sfr_wr && sfr_addr == ADDR_EN_LO) gate_r <= sfr_wdata[GATE_BIT];
      // Access in the cycle of a completion is left out: which instruction owns it is unclear
      if (return_from_interrupt_exec) blk_r <= 1'b1;
      else if (instr_done) blk_r <= 1'b0;
      else if ((sfr_wr || sfr_rd) && sfr_hit) blk_r <= 1'b1;
    end
  end
  a_req_on_poll: assert property ($rose(irq_req) |-> $past(mc_start && last_cycle))
    else $error("request raised outside a final poll cycle");
  a_gate_blocks: assert property ($rose(irq_req) |-> $past(gate_r))
    else $error("request raised with global gate off");
  a_access_holdoff: assert property ($rose(irq_req) |-> !$past(blk_r))
    else $error("request raised during hold-off");
  a_req_stands: assert property (irq_req && !irq_taken |=> irq_req && $stable(irq_vector) && $stable(irq_level))
    else $error("request or vector changed before take");
  a_take_drops: assert property (irq_req && irq_taken |=> !irq_req)
    else $error("request still high after take");
  a_take_marks: assert property (irq_req && irq_taken |=>
    (active_levels[1] || !$past(irq_level)) && (active_levels[0] || $past(irq_level)))
    else $error("active level not recorded on take");
  a_high_exclusive: assert property ($rose(irq_req) |-> !$past(active_levels[1]))
    else $error("call raised during high routine");
  a_low_no_nest: assert property ($rose(irq_req) && !irq_level |-> !$past(active_levels[0]))
    else $error("low call raised during low routine");
  a_return_from_interrupt_high: assert property (return_from_interrupt_exec && !irq_taken && active_levels[1] |=>
    active_levels == {1'b0, $past(active_levels[0])})
    else $error("return did not release high level");
  a_return_from_interrupt_low: assert property (return_from_interrupt_exec && !irq_taken && active_levels == 2'b01 |=> active_levels == 2'b00)
    else $error("return did not release low level");
  a_vector_grid: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h_0073)
    else $error("vector off the eight-byte grid");
  a_tmr_cleared: assert property (irq_req && irq_taken && irq_vector == VEC_TMR0 &&
    !periph_set[SRC_TMR0] && !flag_wr[SRC_TMR0] |=> !flag_q[SRC_TMR0])
    else $error("timer flag not cleared on take");
  // Main scenarios reached
  cover property (irq_req && irq_taken && irq_level);
  cover property (active_levels == 2'b11);
  cover property (return_from_interrupt_exec && active_levels == 2'b01);
endmodule

// ### testbench/tvi_core_model.sv
// Behavioural core: machine-cycle timing, call acceptance and return execution
`timescale 1ns/10ps
module tvi_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [3:0] take_dly,
  input wire logic return_from_interrupt_cmd,
  input wire logic irq_req,
  output logic sample_pt,
  output logic mc_start,
  output logic last_cycle,
  output logic instr_done,
  output logic return_from_interrupt_exec,
  output logic irq_taken
);
  logic [2:0] ph_r;
  logic mc2_r;
  logic pend_r;
  logic [3:0] wait_r;
  // Six clocks a machine cycle; slow mode makes each instruction two machine cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ph_r <= 3'h0;
      mc2_r <= 1'b0;
    end else begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      if (ph_r == 3'h5) mc2_r <= slow && !mc2_r;
    end
  end
  // Strobes stay low in reset so nothing is polled early
  assign mc_start = !rst && ph_r == 3'h0;
  assign sample_pt = !rst && ph_r == 3'h4;
  assign last_cycle = !slow || mc2_r;
  assign instr_done = !rst && last_cycle && ph_r == 3'h5;
  // Return runs as the next instruction to complete
  always_ff @(posedge core_clk) begin
    if (rst) pend_r <= 1'b0;
    else if (return_from_interrupt_cmd) pend_r <= 1'b1;
    else if (instr_done) pend_r <= 1'b0;
  end
  assign return_from_interrupt_exec = pend_r && instr_done;
  // Long call taken a set number of clocks after the request, to try slow acceptance
  always_ff @(posedge core_clk) begin
    if (rst || !irq_req || irq_taken) wait_r <= 4'h0;
    else wait_r <= wait_r + 4'h1;
  end
  assign irq_taken = irq_req && wait_r == take_dly;
endmodule

// ### testbench/two_level_vectored_interrupt_ctrl_tb.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
module two_level_vectored_interrupt_ctrl_tb
  import tvi_pkg::*;
();
  logic core_clk, rst, sample_pt, mc_start, last_cycle, instr_done, return_from_interrupt_exec;
  logic sfr_wr, sfr_rd, sfr_hit, ext0_pin_n, ext1_pin_n, ext0_edge_mode, ext1_edge_mode;
  logic irq_req, irq_level, irq_taken, slow, return_from_interrupt_cmd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cap_edge_sel;
  logic [14:0] flag_wr, flag_wdata, flag_q, periph_set;
  logic [15:0] irq_vector;
  logic [3:0] cap_pin, take_dly;
  logic [1:0] active_levels;
  int n_errors, checks, cyc;
  logic [7:0] ra [4] = '{ADDR_EN_LO, ADDR_EN_HI, ADDR_PRI_LO, ADDR_PRI_HI};
  logic [15:0] vt [15] = '{16'h_0003, 16'h_002B, 16'h_0053, 16'h_000B, 16'h_0033,
    16'h_005B, 16'h_0013, 16'h_003B, 16'h_0063, 16'h_001B, 16'h_0043, 16'h_006B,
    16'h_0023, 16'h_004B, 16'h_0073};
  tvi_ctrl dut (.core_clk, .rst, .sample_pt, .mc_start, .last_cycle, .instr_done, .return_from_interrupt_exec,
    .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit, .flag_wr, .flag_wdata, .flag_q,
    .periph_set, .ext0_pin_n, .ext1_pin_n, .ext0_edge_mode, .ext1_edge_mode, .cap_pin,
    .cap_edge_sel, .irq_req, .irq_vector, .irq_level, .irq_taken, .active_levels);
  tvi_core_model core (.core_clk, .rst, .slow, .take_dly, .return_from_interrupt_cmd, .irq_req, .sample_pt,
    .mc_start, .last_cycle, .instr_done, .return_from_interrupt_exec, .irq_taken);
  // Free-running core clock
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access; read data and hit are combinational, so look before the edge
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] exp, logic hit);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    #1;
    if (!w) chk(sfr_rdata, exp);
    chk(sfr_hit, hit);
    tick();
    sfr_wr = 0;
    sfr_rd = 0;
    tick(); // Idle edge so back-to-back calls never reassign a strobe in one step
  endtask
  task automatic pulse(logic [14:0] ps, logic [14:0] fw, logic [14:0] fd);
    periph_set = ps;
    flag_wr = fw;
    flag_wdata = fd;
    tick();
    periph_set = '0;
    flag_wr = '0;
    tick();
  endtask
  task automatic take(logic [15:0] v, logic l);
    for (int i = 0; i < 400 && irq_taken !== 1'b1; i++) tick();
    chk(irq_taken, 1);
    chk(irq_vector, v);
    chk(irq_level, l);
    tick();
  endtask
  task automatic quiet(int n);
    logic seen;
    seen = 0;
    repeat (n) begin
      tick();
      seen |= irq_req;
    end
    chk(seen, 0);
  endtask
  task automatic ret();
    return_from_interrupt_cmd = 1;
    tick();
    return_from_interrupt_cmd = 0;
    for (int i = 0; i < 40 && return_from_interrupt_exec !== 1'b1; i++) tick();
    tick();
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well above the length of the sequence below
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    {rst, ext0_pin_n, ext1_pin_n, ext0_edge_mode} = 4'hF;
    {sfr_wr, sfr_rd, ext1_edge_mode, slow, return_from_interrupt_cmd} = 5'h0;
    {sfr_addr, sfr_wdata, flag_wr, flag_wdata, periph_set} = '0;
    cap_pin = 4'hF;
    cap_edge_sel = 8'h09;
    take_dly = 4'h0;
    tick(4);
    rst = 0;
    for (int k = 0; k < 4; k++) begin
      acc(0, ra[k], 8'h00, 8'h00, 1);
      acc(1, ra[k], 8'hFF, 8'h00, 1);
      acc(0, ra[k], 8'h00, (k == 2) ? 8'h7F : 8'hFF, 1);
      acc(1, ra[k], (k < 2) ? 8'hFF : 8'h00, 8'h00, 1);
    end
    acc(1, 8'h87, 8'hFF, 8'h00, 0);
    $display("test registers done");
    // All sources at once, low level: served one by one in poll order
    pulse(15'h7FFF, 0, 0);
    for (int i = 0; i < 15; i++) begin
      take(vt[i], 0);
      chk(flag_q[i], (i == 0 || i == 3 || i == 9) ? 0 : 1);
      pulse(0, 15'h1 << i, 0);
      ret();
    end
    $display("test poll order done");
    slow = 1;
    take_dly = 4'h3;
    acc(1, ADDR_PRI_HI, 8'h80, 8'h00, 1);
    pulse(15'h4001, 0, 0);
    take(16'h_0073, 1);
    pulse(0, 15'h4000, 0);
    quiet(30);
    ret();
    take(16'h_0003, 0);
    pulse(15'h4000, 0, 0);
    take(16'h_0073, 1);
    chk(active_levels, 3);
    pulse(0, 15'h4000, 0);
    ret();
    ret();
    chk(active_levels, 0);
    $display("test levels done");
    acc(1, ADDR_EN_LO, 8'h7F, 8'h00, 1);
    pulse(15'h0028, 0, 0);
    quiet(40);
    pulse(0, 15'h0004, 15'h0004);
    chk(flag_q[2], 0);
    pulse(0, 15'h0020, 0);
    acc(1, ADDR_EN_LO, 8'h80, 8'h00, 1);
    quiet(40);
    acc(1, ADDR_EN_LO, 8'h82, 8'h00, 1);
    take(16'h_000B, 0);
    chk(flag_q[3], 0);
    ret();
    $display("test enables done");
    acc(1, ADDR_EN_LO, 8'h84, 8'h00, 1);
    ext1_pin_n = 0;
    take(16'h_0013, 0);
    chk(flag_q[6], 1);
    ext1_pin_n = 1;
    tick(8);
    pulse(0, 15'h0040, 0);
    ret();
    quiet(40);
    cap_pin = 4'hC;
    take(16'h_003B, 0);
    pulse(0, 15'h0080, 0);
    ret();
    cap_pin = 4'hF;
    take(16'h_0033, 0);
    pulse(0, 15'h0010, 0);
    ret();
    acc(1, ADDR_EN_LO, 8'h81, 8'h00, 1);
    ext0_pin_n = 0;
    take(16'h_0003, 0);
    chk(flag_q[0], 0);
    ext0_pin_n = 1;
    ret();
    $display("test pins done");
    stop_test();
  end
endmodule
bind tvi_ctrl tvi_ctrl_checker #(.N_SRC(N_SRC)) chk (.core_clk, .rst, .mc_start, .last_cycle,
  .instr_done, .return_from_interrupt_exec, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_hit, .flag_wr, .flag_q,
  .periph_set, .irq_req, .irq_vector, .irq_level, .irq_taken, .active_levels);
